// file: ddu_pkg.sv
// Package for the dual output converter update and calibration store block
package ddu_pkg;
	localparam int CODE_W = 12;
	localparam int WORD_W = 16;
	localparam int TRIM_W = 8;
	localparam int NUM_TRIM = 8;
	localparam int TRIM_SEL_W = 3;
	localparam int NV_ADDR_W = 8;
	localparam int NV_DEPTH = 256;
	localparam int NV_DATA_W = 16;
	localparam int USER_AREA_W = 2;
	localparam int USER_AREA_SZ = 32;
	localparam int USER_OFS_W = 5;
	localparam logic [CODE_W-1:0] CODE_RESET = 12'h000;
	localparam logic [CODE_W-1:0] CODE_MIDSCALE = 12'h800;
	localparam logic [TRIM_W-1:0] TRIM_RESET = 8'h00;
	localparam logic [NV_DATA_W-1:0] NV_BLANK = 16'hFFFF;
	// Polarity settings
	localparam logic POL_UNIPOLAR = 1'b0;
	localparam logic POL_BIPOLAR = 1'b1;
	// Update modes
	localparam logic UPD_IMMEDIATE = 1'b0;
	localparam logic UPD_DELAYED = 1'b1;
endpackage

// file: ddu_properties.sv
// Concurrent checks on the code update, trim load and calibration store ports
`timescale 1ns/10ps
module ddu_properties
	import ddu_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Code path
	input wire logic code_wr_ch0,
	input wire logic code_wr_ch1,
	input wire logic [WORD_W-1:0] code_wdata,
	input wire logic polarity_ch0,
	input wire logic polarity_ch1,
	input wire logic update_mode,
	input wire logic update_interval_timer,
	input wire logic external_update_strobe_n,
	input wire logic [CODE_W-1:0] dac_code_ch0,
	input wire logic [CODE_W-1:0] dac_code_ch1,
	input wire logic update_pending,
	// Trim and store
	input wire logic trim_wr,
	input wire logic [TRIM_SEL_W-1:0] trim_sel,
	input wire logic [TRIM_W-1:0] trim_wdata,
	input wire logic [NUM_TRIM*TRIM_W-1:0] trim_values,
	input wire logic nv_wr,
	input wire logic nv_rd,
	input wire logic [NV_ADDR_W-1:0] nv_addr,
	input wire logic [NV_DATA_W-1:0] nv_rdata,
	input wire logic nv_rvalid,
	input wire logic nv_wr_rejected,
	input wire logic [USER_AREA_W-1:0] nv_user_area
);
	// One clock domain, so clocking and reset are shared by all checks
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	AST_IMM_UNI: assert property (!update_mode && code_wr_ch0 && !polarity_ch0 |=>
		dac_code_ch0 == $past(code_wdata[CODE_W-1:0])) else $error("unipolar write not applied");
	AST_IMM_BIP: assert property (!update_mode && code_wr_ch1 && polarity_ch1 |=>
		dac_code_ch1 == ($past(code_wdata[CODE_W-1:0]) ^ 12'h800)) else $error("bipolar map wrong");
	// Filter must have seen both sources high for a while before a hold is expected
	AST_DLY_HOLD: assert property ((update_interval_timer && external_update_strobe_n)[*6] ##0
		(update_mode && code_wr_ch0) |=> update_pending && $stable(dac_code_ch0))
		else $error("delayed write changed output");
	AST_DLY_FLUSH: assert property ((!external_update_strobe_n && !code_wr_ch0 && !code_wr_ch1)[*7]
		|-> !update_pending) else $error("held code not applied on strobe");
	AST_TRIM_LOAD: assert property (trim_wr |=>
		trim_values[$past(trim_sel)*TRIM_W +: TRIM_W] == $past(trim_wdata)) else $error("trim not loaded");
	AST_FACTORY_REJ: assert property (nv_wr && nv_addr[NV_ADDR_W-1] |=> nv_wr_rejected)
		else $error("factory write not rejected");
	AST_USER_WR: assert property (nv_wr && !nv_addr[NV_ADDR_W-1] |=> !nv_wr_rejected &&
		nv_user_area == $past(nv_addr[USER_OFS_W +: USER_AREA_W])) else $error("user area write wrong");
	AST_READ_VALID: assert property (nv_rd |=> nv_rvalid) else $error("read not answered");
	// Read data must stay put between reads so the host can take it late
	AST_READ_HOLD: assert property (!nv_rd |=> $stable(nv_rdata)) else $error("read data moved");
endmodule

// file: ddu_top.sv
// Two channel output update logic with trim converters and calibration store
`timescale 1ns/10ps
// Overview of operation
// - Two output channels each take their own 12-bit code written by the host.
// - Each channel has its own polarity input choosing unipolar or bipolar range.
// - Unipolar codes are straight binary with zero giving the lowest level.
// - Bipolar codes are sign-extended two's complement with F800 hex the lowest level.
// - Immediate mode applies a write to the output on the cycle after the write.
// - Delayed mode holds the output until the timer or strobe is seen low.
// - The update mode is a software setting that may be changed at any time.
// - Four input-path and four output-path trim converters are host loadable.
// - The host copies trim values to the nonvolatile store, which stays readable.
// - Writes to the factory upper half of the store are rejected.
// - The lower half is writable and split into four user areas.
module ddu_top
	import ddu_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Channel code writes
	input wire logic code_wr_ch0,
	input wire logic code_wr_ch1,
	input wire logic [WORD_W-1:0] code_wdata,
	// Channel settings
	input wire logic polarity_ch0,
	input wire logic polarity_ch1,
	input wire logic update_mode,
	// Update sources, active low levels
	input wire logic update_interval_timer,
	input wire logic external_update_strobe_n,
	// Converter codes toward analog_out_ch0_pin and analog_out_ch1_pin
	output logic [CODE_W-1:0] dac_code_ch0,
	output logic [CODE_W-1:0] dac_code_ch1,
	output logic update_pending,
	// Trim converter load
	input wire logic trim_wr,
	input wire logic [TRIM_SEL_W-1:0] trim_sel,
	input wire logic [TRIM_W-1:0] trim_wdata,
	output logic [NUM_TRIM*TRIM_W-1:0] trim_values,
	// Calibration store access
	input wire logic nv_wr,
	input wire logic nv_rd,
	input wire logic [NV_ADDR_W-1:0] nv_addr,
	input wire logic [NV_DATA_W-1:0] nv_wdata,
	output logic [NV_DATA_W-1:0] nv_rdata,
	output logic nv_rvalid,
	output logic nv_wr_rejected,
	output logic [USER_AREA_W-1:0] nv_user_area
);

	// Host word to converter code; bipolar keeps the sign-extended low twelve bits
	// and flips the sign so F800 lands on the lowest level of the converter
	function automatic logic [CODE_W-1:0] to_code(input logic [WORD_W-1:0] w, input logic pol);
		logic [CODE_W-1:0] c;
		c = w[CODE_W-1:0];
		if (pol == POL_BIPOLAR) begin
			c = w[CODE_W-1:0] ^ CODE_MIDSCALE;
		end
		return c;
	endfunction

	// Factory half is the upper half of the store
	function automatic logic is_factory(input logic [NV_ADDR_W-1:0] a);
		return a[NV_ADDR_W-1];
	endfunction

	// Input synchronisers for the two update sources
	logic [2:0] tmr_sync;
	logic [2:0] ext_sync;
	logic tmr_low;
	logic ext_low;
	logic [2:0] next_tmr_sync;
	logic [2:0] next_ext_sync;
	logic next_tmr_low;
	logic next_ext_low;

	always_comb begin
		next_tmr_sync = {tmr_sync[1:0], update_interval_timer};
		next_ext_sync = {ext_sync[1:0], external_update_strobe_n};
		next_tmr_low = tmr_low;
		next_ext_low = ext_low;
		// Change counts only when stages two and three agree
		if (tmr_sync[2] == tmr_sync[1]) begin
			next_tmr_low = ~tmr_sync[2];
		end
		if (ext_sync[2] == ext_sync[1]) begin
			next_ext_low = ~ext_sync[2];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tmr_sync <= 3'h7;
			ext_sync <= 3'h7;
			tmr_low <= 1'b0;
			ext_low <= 1'b0;
		end else begin
			tmr_sync <= next_tmr_sync;
			ext_sync <= next_ext_sync;
			tmr_low <= next_tmr_low;
			ext_low <= next_ext_low;
		end
	end

	// Channel holding registers and converter codes
	logic [CODE_W-1:0] hold_ch0;
	logic [CODE_W-1:0] hold_ch1;
	logic [1:0] pend;
	logic [CODE_W-1:0] next_hold_ch0;
	logic [CODE_W-1:0] next_hold_ch1;
	logic [1:0] next_pend;
	logic [CODE_W-1:0] next_dac_ch0;
	logic [CODE_W-1:0] next_dac_ch1;
	logic upd_now;

	// Level sensitive: while a source stays low, every held write goes out at once
	assign upd_now = tmr_low | ext_low;

	always_comb begin
		next_hold_ch0 = hold_ch0;
		next_hold_ch1 = hold_ch1;
		next_pend = pend;
		next_dac_ch0 = dac_code_ch0;
		next_dac_ch1 = dac_code_ch1;
		// Mode switches take effect on the next write or update
		if (update_mode == UPD_IMMEDIATE) begin
			// Leftover held codes still go out on an update
			if (pend[0] && upd_now) begin
				next_dac_ch0 = hold_ch0;
				next_pend[0] = 1'b0;
			end
			if (pend[1] && upd_now) begin
				next_dac_ch1 = hold_ch1;
				next_pend[1] = 1'b0;
			end
			// A fresh write wins and drops the stale held code, so it cannot overwrite later
			if (code_wr_ch0) begin
				next_dac_ch0 = to_code(code_wdata, polarity_ch0);
				next_pend[0] = 1'b0;
			end
			if (code_wr_ch1) begin
				next_dac_ch1 = to_code(code_wdata, polarity_ch1);
				next_pend[1] = 1'b0;
			end
		end else begin
			if (pend[0] && upd_now) begin
				next_dac_ch0 = hold_ch0;
				next_pend[0] = 1'b0;
			end
			if (pend[1] && upd_now) begin
				next_dac_ch1 = hold_ch1;
				next_pend[1] = 1'b0;
			end
			// A new write replaces the held value and wins over a same-cycle update
			if (code_wr_ch0) begin
				next_hold_ch0 = to_code(code_wdata, polarity_ch0);
				next_pend[0] = 1'b1;
			end
			if (code_wr_ch1) begin
				next_hold_ch1 = to_code(code_wdata, polarity_ch1);
				next_pend[1] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hold_ch0 <= CODE_RESET;
			hold_ch1 <= CODE_RESET;
			pend <= 2'h0;
			dac_code_ch0 <= CODE_RESET;
			dac_code_ch1 <= CODE_RESET;
		end else begin
			hold_ch0 <= next_hold_ch0;
			hold_ch1 <= next_hold_ch1;
			pend <= next_pend;
			dac_code_ch0 <= next_dac_ch0;
			dac_code_ch1 <= next_dac_ch1;
		end
	end

	assign update_pending = |pend;

	// Trim converters: 0..3 input path, 4..7 output path
	logic [TRIM_W-1:0] trim [NUM_TRIM];
	logic [TRIM_W-1:0] next_trim [NUM_TRIM];

	always_comb begin
		next_trim = trim;
		if (trim_wr) begin
			next_trim[trim_sel] = trim_wdata;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < NUM_TRIM; i++) begin
				trim[i] <= TRIM_RESET;
			end
		end else begin
			trim <= next_trim;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_TRIM; g++) begin : g_trim
			assign trim_values[g*TRIM_W +: TRIM_W] = trim[g];
		end
	endgenerate

	// Calibration store; contents are not cleared by reset, as a nonvolatile part
	logic [NV_DATA_W-1:0] nv_mem [NV_DEPTH];
	logic [NV_DATA_W-1:0] next_nv_rdata;
	logic next_nv_rvalid;
	logic next_nv_rej;
	logic [USER_AREA_W-1:0] next_area;
	logic nv_we;

	initial begin
		for (int i = 0; i < NV_DEPTH; i++) begin
			nv_mem[i] = NV_BLANK;
		end
	end

	always_comb begin
		nv_we = nv_wr && !is_factory(nv_addr);
		next_nv_rej = nv_wr && is_factory(nv_addr);
		next_nv_rvalid = nv_rd;
		next_nv_rdata = nv_rdata;
		if (nv_rd) begin
			next_nv_rdata = nv_mem[nv_addr];
		end
		next_area = nv_user_area;
		if (nv_we) begin
			next_area = nv_addr[USER_OFS_W +: USER_AREA_W];
		end
	end

	// Store array has no reset so it may map onto memory
	always_ff @(posedge clk) begin
		if (nv_we) begin
			nv_mem[nv_addr] <= nv_wdata;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			nv_rdata <= NV_BLANK;
			nv_rvalid <= 1'b0;
			nv_wr_rejected <= 1'b0;
			nv_user_area <= 2'h0;
		end else begin
			nv_rdata <= next_nv_rdata;
			nv_rvalid <= next_nv_rvalid;
			nv_wr_rejected <= next_nv_rej;
			nv_user_area <= next_area;
		end
	end

endmodule

// file: ddu_top_tb.sv
// Self-checking bench for the output update and calibration store block
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
	$display("[ERR] %0t got %h expected %h", $time, (a), (b)); end end
module ddu_top_tb
	import ddu_pkg::*;
;
	logic clk = 0, rstn = 0, code_wr_ch0 = 0, code_wr_ch1 = 0, polarity_ch0 = 0, polarity_ch1 = 0;
	logic update_mode = 0, update_interval_timer = 1, external_update_strobe_n = 1;
	logic trim_wr = 0, nv_wr = 0, nv_rd = 0, update_pending, nv_rvalid, nv_wr_rejected;
	logic [WORD_W-1:0] code_wdata = '0;
	logic [TRIM_SEL_W-1:0] trim_sel = '0;
	logic [TRIM_W-1:0] trim_wdata = '0;
	logic [NV_ADDR_W-1:0] nv_addr = '0;
	logic [NV_DATA_W-1:0] nv_wdata = '0, nv_rdata;
	logic [CODE_W-1:0] dac_code_ch0, dac_code_ch1;
	logic [NUM_TRIM*TRIM_W-1:0] trim_values;
	logic [USER_AREA_W-1:0] nv_user_area;
	int err_count = 0, checks = 0, cyc = 0;
	logic [WORD_W-1:0] words [5] = '{16'h0000, 16'h0FFF, 16'hF800, 16'h07FF, 16'h0000};
	logic [CODE_W-1:0] exps [5] = '{12'h000, 12'hFFF, 12'h000, 12'hFFF, 12'h800};
	ddu_top i_ddu_top (.clk, .rstn, .code_wr_ch0, .code_wr_ch1, .code_wdata, .polarity_ch0,
		.polarity_ch1, .update_mode, .update_interval_timer, .external_update_strobe_n,
		.dac_code_ch0, .dac_code_ch1, .update_pending, .trim_wr, .trim_sel, .trim_wdata,
		.trim_values, .nv_wr, .nv_rd, .nv_addr, .nv_wdata, .nv_rdata, .nv_rvalid,
		.nv_wr_rejected, .nv_user_area);
	// 8 ns period
	initial begin
		forever #4 clk = ~clk;
	end
	// Hang guard; the whole sequence needs well under 400 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			err_count++;
			$display("[ERR] %0t timeout", $time);
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// One-cycle write strobe; the polarity of the addressed channel is set with it
	task automatic wr_code(input logic ch, input logic pol, input logic [WORD_W-1:0] w);
		@(posedge clk);
		code_wr_ch0 <= !ch;
		code_wr_ch1 <= ch;
		code_wdata <= w;
		if (ch) polarity_ch1 <= pol;
		else polarity_ch0 <= pol;
		@(posedge clk);
		code_wr_ch0 <= 0;
		code_wr_ch1 <= 0;
		#1;
	endtask
	// Store access; returns just after the taking edge so the pulses can be seen
	task automatic nv_op(input logic wr, input logic [NV_ADDR_W-1:0] a,
		input logic [NV_DATA_W-1:0] d);
		@(posedge clk);
		nv_wr <= wr;
		nv_rd <= !wr;
		nv_addr <= a;
		nv_wdata <= d;
		@(posedge clk);
		nv_wr <= 0;
		nv_rd <= 0;
		#1;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rstn <= 1;
		for (int ch = 0; ch < 2; ch++) begin
			for (int i = 0; i < 5; i++) begin
				wr_code(ch[0], i > 1, words[i]);
				`CHK(ch ? dac_code_ch1 : dac_code_ch0, exps[i])
			end
		end
		$display("test immediate done");
		@(posedge clk);
		update_mode <= 1;
		wr_code(0, 0, 16'h0123);
		wr_code(0, 0, 16'h0456);
		repeat (6) @(posedge clk);
		#1 `CHK(dac_code_ch0, 12'h800)
		`CHK(update_pending, 1'b1)
		@(posedge clk);
		external_update_strobe_n <= 0;
		repeat (8) @(posedge clk);
		#1 `CHK(dac_code_ch0, 12'h456)
		`CHK(update_pending, 1'b0)
		@(posedge clk);
		external_update_strobe_n <= 1;
		repeat (6) @(posedge clk);
		wr_code(1, 1, 16'hF801);
		repeat (6) @(posedge clk);
		#1 `CHK(dac_code_ch1, 12'h800)
		@(posedge clk);
		update_interval_timer <= 0;
		repeat (8) @(posedge clk);
		#1 `CHK(dac_code_ch1, 12'h001)
		@(posedge clk);
		update_interval_timer <= 1;
		repeat (6) @(posedge clk);
		wr_code(0, 0, 16'h0321);
		// Strobe goes low so its filtered level first shows on the edge of the next write
		@(posedge clk);
		update_mode <= 0;
		external_update_strobe_n <= 0;
		repeat (3) @(posedge clk);
		wr_code(0, 0, 16'h0ABC);
		`CHK(dac_code_ch0, 12'hABC)
		`CHK(update_pending, 1'b0)
		@(posedge clk);
		external_update_strobe_n <= 1;
		wr_code(1, 0, 16'h0ABC);
		`CHK(dac_code_ch1, 12'hABC)
		$display("test delayed done");
		for (int i = 0; i < NUM_TRIM; i++) begin // Host loads every trim
			@(posedge clk);
			trim_wr <= 1;
			trim_sel <= i[TRIM_SEL_W-1:0];
			trim_wdata <= 8'h30 + i[7:0];
		end
		@(posedge clk);
		trim_wr <= 0;
		#1;
		for (int i = 0; i < NUM_TRIM; i++) `CHK(trim_values[i*TRIM_W +: TRIM_W], 8'h30 + i[7:0])
		$display("test trim done");
		nv_op(1, 8'h05, 16'h1234);
		`CHK({nv_wr_rejected, nv_user_area}, 3'b000)
		nv_op(1, 8'h65, 16'h5678);
		`CHK({nv_wr_rejected, nv_user_area}, 3'b011)
		nv_op(1, 8'h85, 16'h9ABC);
		`CHK({nv_wr_rejected, nv_user_area}, 3'b111)
		nv_op(0, 8'h05, 16'h0000);
		`CHK({nv_rvalid, nv_rdata}, 17'h1_1234)
		nv_op(0, 8'h65, 16'h0000);
		`CHK({nv_rvalid, nv_rdata}, 17'h1_5678)
		nv_op(0, 8'h85, 16'h0000);
		`CHK(nv_rdata, NV_BLANK)
		$display("test store done");
		complete_run();
	end
endmodule
bind ddu_top ddu_properties i_ddu_properties (.clk, .rstn, .code_wr_ch0, .code_wr_ch1,
	.code_wdata, .polarity_ch0, .polarity_ch1, .update_mode, .update_interval_timer,
	.external_update_strobe_n, .dac_code_ch0, .dac_code_ch1, .update_pending, .trim_wr,
	.trim_sel, .trim_wdata, .trim_values, .nv_wr, .nv_rd, .nv_addr,
	.nv_rdata, .nv_rvalid, .nv_wr_rejected, .nv_user_area);
